// *** rtl/rtc_pkg.sv ***
// rtc_pkg: addresses, field positions, masks and carrier types of the
// transceiver control register bank.
// assumes one system clock; the serial pins are asynchronous to it.
package rtc_pkg;

    // ------------------------------------------------------------
    // command and register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] RTC_ADDR_CLEAR = 8'h30;
    localparam logic [7:0] RTC_ADDR_GEN = 8'h31;
    localparam logic [7:0] RTC_ADDR_RX = 8'h32;
    localparam logic [7:0] RTC_ADDR_TX = 8'h33;
    localparam logic [7:0] RTC_ADDR_SYNTH = 8'h34;
    localparam logic [7:0] RTC_ADDR_RB_GEN = 8'hc1;
    localparam logic [7:0] RTC_ADDR_RB_RX = 8'hc2;
    localparam logic [7:0] RTC_ADDR_RB_TX = 8'hc3;

    localparam logic [4:0] RTC_LEN_ADDR = 5'h08;
    localparam logic [4:0] RTC_LEN_BYTE = 5'h08;
    localparam logic [4:0] RTC_LEN_WORD = 5'h10;
    localparam logic [4:0] RTC_LEN_NONE = 5'h00;

    // ------------------------------------------------------------
    // reset values and writable-bit masks
    // ------------------------------------------------------------
    localparam logic [7:0] RTC_GLOBAL_CLEAR_COMMAND = 8'h00;
    localparam logic [15:0] RTC_RX_RST = 16'h0000;
    localparam logic [7:0] RTC_TX_RST = 8'h00;
    localparam logic [15:0] RTC_SYNTH_RST = 16'h0000;
    localparam logic [7:0] RTC_GEN_MASK = 8'hff;
    localparam logic [15:0] RTC_RX_MASK = 16'h847f;
    localparam logic [7:0] RTC_TX_MASK = 8'hcf;
    localparam logic [15:0] RTC_SYNTH_MASK = 16'h7f3f;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int RTC_GE_LNA = 7;
    localparam int RTC_GE_LO = 6;
    localparam int RTC_GE_IFS = 5;
    localparam int RTC_GE_BIAS = 4;
    localparam int RTC_GE_EXTOSC = 3;
    localparam int RTC_GE_RFS = 2;
    localparam int RTC_GE_RXM = 1;
    localparam int RTC_GE_TXM = 0;
    localparam int RTC_RX_SB = 15;
    localparam int RTC_RX_IF = 10;
    localparam int RTC_RX_MG = 5;
    localparam int RTC_RX_AG = 3;
    localparam int RTC_RX_IR = 2;
    localparam int RTC_RX_DIV = 0;
    localparam int RTC_TX_GAIN = 6;
    localparam int RTC_TX_SB = 3;
    localparam int RTC_TX_SR = 2;
    localparam int RTC_TX_DIV = 0;
    localparam int RTC_SY_MODE = 11;
    localparam int RTC_SY_DITHER = 10;
    localparam int RTC_SY_RES = 9;
    localparam int RTC_SY_PATH = 8;

    localparam logic [1:0] RTC_DIV_RESERVED = 2'h3;
    localparam logic [1:0] RTC_TXG_ALIAS = 2'h3;
    localparam logic [1:0] RTC_TXG_ZERO = 2'h0;
    localparam logic [3:0] RTC_MODE_MASH = 4'hc;
    localparam logic [3:0] RTC_MODE_MASH_PF = 4'hd;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RTC_ST_ADDR,
        RTC_ST_WDATA,
        RTC_ST_RDATA,
        RTC_ST_SKIP
    } rtc_state_type;

    typedef struct packed {
        logic low_noise_amp_on;
        logic local_osc_output_on;
        logic intermediate_synth_on;
        logic external_osc_input_on;
        logic high_freq_synth_on;
        logic receive_mixer_on;
        logic transmit_mixer_on;
        logic bias_on;
        logic receive_sideband_select;
        logic if_is_225;
        logic [1:0] mixer_gain_step;
        logic [1:0] amp_gain_step;
        logic image_reject_on;
        logic [1:0] receive_lo_divider;
        logic receive_div_reserved;
        logic [1:0] transmit_atten_3db;
        logic transmit_sideband_select;
        logic sideband_reject_on;
        logic [1:0] transmit_lo_divider;
        logic transmit_div_reserved;
        logic synth_mode_valid;
        logic synth_post_filter;
        logic synth_dither_on;
        logic synth_frac_16bit;
        logic synth_to_transmit;
    } rtc_ctrl_type;

endpackage

// *** rtl/rtc_control_regs.sv ***
// rtc_control_regs: write-only control register bank with read-back
// copies, reached over a three-wire serial control port plus select.
// assumes serial pins asynchronous to i_sys_clk, sclk well below
// a quarter of the system clock rate.
`timescale 1ns/1ps

module rtc_control_regs
    import rtc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_select_n,
    input wire logic i_serial_clk,
    input wire logic i_command_data,
    output logic o_reply_data,
    output logic o_reply_data_oe,
    output logic o_powersave,
    output rtc_ctrl_type o_ctrl
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic sel_n_s1_r, sel_n_s2_r;
    logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
    logic cdata_s1_r, cdata_s2_r;

    always_ff @(posedge i_sys_clk) begin
        sel_n_s1_r <= i_select_n;
        sel_n_s2_r <= sel_n_s1_r;
        sclk_s1_r <= i_serial_clk;
        sclk_s2_r <= sclk_s1_r;
        sclk_s3_r <= sclk_s2_r;
        cdata_s1_r <= i_command_data;
        cdata_s2_r <= cdata_s1_r;
    end

    wire selected = ~sel_n_s2_r;
    wire sclk_rise = sclk_s2_r & ~sclk_s3_r;
    wire sclk_fall = ~sclk_s2_r & sclk_s3_r;

    // ------------------------------------------------------------
    // serial framing
    // ------------------------------------------------------------
    rtc_state_type state_r, state_nxt;
    logic [4:0] bit_cnt_r, bit_cnt_nxt;
    logic [15:0] shift_r;
    logic [7:0] addr_r;
    logic [15:0] tx_shift_r;
    logic [7:0] gen_r;
    logic [15:0] rx_r;
    logic [7:0] tx_r;
    logic [15:0] synth_r;

    wire [15:0] shift_in = {shift_r[14:0], cdata_s2_r};
    wire [4:0] bit_cnt_inc = bit_cnt_r + 5'h01;
    wire [7:0] addr_in = shift_in[7:0];
    wire addr_done = (state_r == RTC_ST_ADDR) && sclk_rise
        && (bit_cnt_inc == RTC_LEN_ADDR);

    // write length per address; zero means not writable
    wire [4:0] wr_len;
    assign wr_len = (addr_in == RTC_ADDR_GEN) ? RTC_LEN_BYTE :
        (addr_in == RTC_ADDR_RX) ? RTC_LEN_WORD :
        (addr_in == RTC_ADDR_TX) ? RTC_LEN_BYTE :
        (addr_in == RTC_ADDR_SYNTH) ? RTC_LEN_WORD : RTC_LEN_NONE;
    logic [4:0] len_r;

    // read-back value left aligned so the msb goes out first
    wire rd_hit;
    wire [15:0] rd_value;
    assign rd_hit = (addr_in == RTC_ADDR_RB_GEN)
        || (addr_in == RTC_ADDR_RB_RX) || (addr_in == RTC_ADDR_RB_TX);
    assign rd_value = (addr_in == RTC_ADDR_RB_GEN) ? {gen_r, 8'h00} :
        (addr_in == RTC_ADDR_RB_RX) ? rx_r :
        (addr_in == RTC_ADDR_RB_TX) ? {tx_r, 8'h00} : 16'h0000;

    wire clear_cmd = addr_done && (addr_in == RTC_ADDR_CLEAR);
    wire write_done = (state_r == RTC_ST_WDATA) && sclk_rise
        && (bit_cnt_inc == len_r);

    always_comb begin
        state_nxt = state_r;
        bit_cnt_nxt = bit_cnt_r;
        if (!selected) begin
            state_nxt = RTC_ST_ADDR;
            bit_cnt_nxt = 5'h00;
        end else if (sclk_rise) begin
            case (state_r)
                RTC_ST_ADDR: begin
                    bit_cnt_nxt = bit_cnt_inc;
                    if (addr_done) begin
                        bit_cnt_nxt = 5'h00;
                        if (wr_len != RTC_LEN_NONE) begin
                            state_nxt = RTC_ST_WDATA;
                        end else if (rd_hit) begin
                            state_nxt = RTC_ST_RDATA;
                        end else begin
                            state_nxt = RTC_ST_SKIP;
                        end
                    end
                end
                RTC_ST_WDATA: begin
                    bit_cnt_nxt = bit_cnt_inc;
                    if (write_done) begin
                        state_nxt = RTC_ST_SKIP;
                    end
                end
                default: begin
                    state_nxt = state_r;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state_r <= RTC_ST_ADDR;
            bit_cnt_r <= 5'h00;
            shift_r <= 16'h0000;
            addr_r <= 8'h00;
            len_r <= RTC_LEN_NONE;
        end else begin
            state_r <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            if (sclk_rise && selected) begin
                shift_r <= shift_in;
            end
            if (addr_done) begin
                addr_r <= addr_in;
                len_r <= wr_len;
            end
        end
    end

    // ------------------------------------------------------------
    // reply line: changes on the falling serial edge so the host
    // samples a settled bit on the next rising edge
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            tx_shift_r <= 16'h0000;
            o_reply_data <= 1'b0;
            o_reply_data_oe <= 1'b0;
        end else begin
            o_reply_data_oe <= selected && (state_nxt == RTC_ST_RDATA);
            if (addr_done && rd_hit) begin
                tx_shift_r <= rd_value;
            end else if (sclk_fall && state_r == RTC_ST_RDATA) begin
                o_reply_data <= tx_shift_r[15];
                tx_shift_r <= {tx_shift_r[14:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    wire wr_gen = write_done && (addr_r == RTC_ADDR_GEN);
    wire wr_rx = write_done && (addr_r == RTC_ADDR_RX);
    wire wr_tx = write_done && (addr_r == RTC_ADDR_TX);
    wire wr_synth = write_done && (addr_r == RTC_ADDR_SYNTH);

    // reserved bits are dropped on the way in, so they read back zero
    always_ff @(posedge i_sys_clk) begin
        if (i_reset || clear_cmd) begin
            gen_r <= RTC_GLOBAL_CLEAR_COMMAND;
            rx_r <= RTC_RX_RST;
            tx_r <= RTC_TX_RST;
            synth_r <= RTC_SYNTH_RST;
        end else begin
            if (wr_gen) begin
                gen_r <= shift_in[7:0] & RTC_GEN_MASK;
            end
            if (wr_rx) begin
                rx_r <= shift_in & RTC_RX_MASK;
            end
            if (wr_tx) begin
                tx_r <= shift_in[7:0] & RTC_TX_MASK;
            end
            if (wr_synth) begin
                synth_r <= shift_in & RTC_SYNTH_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------
    wire any_block_on = gen_r[RTC_GE_LNA] | gen_r[RTC_GE_LO]
        | gen_r[RTC_GE_IFS] | gen_r[RTC_GE_EXTOSC] | gen_r[RTC_GE_RFS]
        | gen_r[RTC_GE_RXM] | gen_r[RTC_GE_TXM];
    wire [3:0] mode = synth_r[RTC_SY_MODE +: 4];
    wire [1:0] txg = tx_r[RTC_TX_GAIN +: 2];
    rtc_ctrl_type ctrl_nxt;

    always_comb begin
        ctrl_nxt.low_noise_amp_on = gen_r[RTC_GE_LNA];
        // the lo divider must be set by the host first; the lo output
        // enable is passed through untouched
        ctrl_nxt.local_osc_output_on = gen_r[RTC_GE_LO];
        ctrl_nxt.intermediate_synth_on = gen_r[RTC_GE_IFS];
        ctrl_nxt.external_osc_input_on = gen_r[RTC_GE_EXTOSC];
        ctrl_nxt.high_freq_synth_on = gen_r[RTC_GE_RFS];
        ctrl_nxt.receive_mixer_on = gen_r[RTC_GE_RXM];
        ctrl_nxt.transmit_mixer_on = gen_r[RTC_GE_TXM];
        // the stored pre-enable bit is never set by hardware
        ctrl_nxt.bias_on = gen_r[RTC_GE_BIAS] | any_block_on;
        ctrl_nxt.receive_sideband_select = rx_r[RTC_RX_SB];
        ctrl_nxt.if_is_225 = rx_r[RTC_RX_IF];
        ctrl_nxt.mixer_gain_step = rx_r[RTC_RX_MG +: 2];
        ctrl_nxt.amp_gain_step = rx_r[RTC_RX_AG +: 2];
        ctrl_nxt.image_reject_on = rx_r[RTC_RX_IR];
        ctrl_nxt.receive_lo_divider = rx_r[RTC_RX_DIV +: 2];
        ctrl_nxt.receive_div_reserved =
            (rx_r[RTC_RX_DIV +: 2] == RTC_DIV_RESERVED);
        // code 3 aliases to no attenuation
        ctrl_nxt.transmit_atten_3db =
            (txg == RTC_TXG_ALIAS) ? RTC_TXG_ZERO : txg;
        ctrl_nxt.transmit_sideband_select = tx_r[RTC_TX_SB];
        ctrl_nxt.sideband_reject_on = tx_r[RTC_TX_SR];
        ctrl_nxt.transmit_lo_divider = tx_r[RTC_TX_DIV +: 2];
        ctrl_nxt.transmit_div_reserved =
            (tx_r[RTC_TX_DIV +: 2] == RTC_DIV_RESERVED);
        ctrl_nxt.synth_mode_valid =
            (mode == RTC_MODE_MASH) || (mode == RTC_MODE_MASH_PF);
        ctrl_nxt.synth_post_filter = (mode == RTC_MODE_MASH_PF);
        ctrl_nxt.synth_dither_on = synth_r[RTC_SY_DITHER];
        ctrl_nxt.synth_frac_16bit = synth_r[RTC_SY_RES];
        ctrl_nxt.synth_to_transmit = synth_r[RTC_SY_PATH];
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_ctrl <= '0;
            o_powersave <= 1'b1;
        end else begin
            o_ctrl <= ctrl_nxt;
            o_powersave <= ~(gen_r[RTC_GE_BIAS] | any_block_on);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_clear_all_regs: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        clear_cmd |=> (gen_r == RTC_GLOBAL_CLEAR_COMMAND) && (rx_r == RTC_RX_RST)
            && (tx_r == RTC_TX_RST) && (synth_r == RTC_SYNTH_RST))
        else $error("clear command left a register bit set");

    chk_clear_powersave: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        clear_cmd |=> ##1 o_powersave && !o_ctrl.bias_on
            && !o_ctrl.low_noise_amp_on && !o_ctrl.transmit_mixer_on)
        else $error("device not in powersave after clear");

    chk_enable_map: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        ##1 (o_ctrl.low_noise_amp_on == $past(gen_r[RTC_GE_LNA]))
            && (o_ctrl.transmit_mixer_on == $past(gen_r[RTC_GE_TXM]))
            && (o_ctrl.receive_mixer_on == $past(gen_r[RTC_GE_RXM])))
        else $error("enable output does not follow its bit");

    chk_bias_on: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        $past(gen_r != RTC_GLOBAL_CLEAR_COMMAND) |-> o_ctrl.bias_on)
        else $error("bias off while a block is enabled");

    chk_readback_load: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        (addr_done && addr_in == RTC_ADDR_RB_RX)
            |=> (tx_shift_r == $past(rx_r)))
        else $error("read-back does not match receive control");

    chk_rx_write: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        (wr_rx && !clear_cmd) |=> (rx_r == ($past(shift_in) & RTC_RX_MASK)))
        else $error("receive control write not stored");

    chk_tx_gain: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        (tx_r[RTC_TX_GAIN +: 2] == RTC_TXG_ALIAS) [*2]
            |-> (o_ctrl.transmit_atten_3db == RTC_TXG_ZERO))
        else $error("tx gain code three not zero attenuation");

    chk_rx_div_res: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        ##1 o_ctrl.receive_div_reserved
            == ($past(rx_r[RTC_RX_DIV +: 2]) == RTC_DIV_RESERVED))
        else $error("rx divider reserved flag wrong");

    chk_synth_mode: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        ##1 o_ctrl.synth_mode_valid
            == ($past(synth_r[RTC_SY_MODE + 1 +: 3]) == RTC_MODE_MASH[3:1]))
        else $error("synth mode validity wrong");

    chk_reply_quiet: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        !selected |=> !o_reply_data_oe)
        else $error("reply driven while deselected");

    chk_bias_idle: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        $past(gen_r == RTC_GLOBAL_CLEAR_COMMAND) |-> !o_ctrl.bias_on)
        else $error("bias on while every block is disabled");

    chk_powersave_map: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        ##1 o_powersave == ($past(gen_r) == RTC_GLOBAL_CLEAR_COMMAND))
        else $error("powersave does not follow the enables");

    chk_rx_sideband: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        ##1 o_ctrl.receive_sideband_select == $past(rx_r[RTC_RX_SB]))
        else $error("rx sideband select does not follow its bit");

    chk_if_mode: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        ##1 o_ctrl.if_is_225 == $past(rx_r[RTC_RX_IF]))
        else $error("if mode does not follow its bit");

    chk_mixer_gain: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        ##1 o_ctrl.mixer_gain_step == $past(rx_r[RTC_RX_MG +: 2]))
        else $error("mixer gain step does not follow its field");

    chk_amp_gain: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        ##1 o_ctrl.amp_gain_step == $past(rx_r[RTC_RX_AG +: 2]))
        else $error("amp gain step does not follow its field");

    chk_image_reject: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        ##1 o_ctrl.image_reject_on == $past(rx_r[RTC_RX_IR]))
        else $error("image reject mode does not follow its bit");

    chk_tx_sideband: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        ##1 o_ctrl.transmit_sideband_select == $past(tx_r[RTC_TX_SB]))
        else $error("tx sideband select does not follow its bit");

    chk_sb_reject: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        ##1 o_ctrl.sideband_reject_on == $past(tx_r[RTC_TX_SR]))
        else $error("sideband reject mode does not follow its bit");

    chk_synth_dither: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        ##1 o_ctrl.synth_dither_on == $past(synth_r[RTC_SY_DITHER]))
        else $error("dither enable does not follow its bit");

    chk_synth_res: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        ##1 o_ctrl.synth_frac_16bit == $past(synth_r[RTC_SY_RES]))
        else $error("resolution select does not follow its bit");

    chk_synth_path: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        ##1 o_ctrl.synth_to_transmit == $past(synth_r[RTC_SY_PATH]))
        else $error("synth path select does not follow its bit");

    chk_tx_write: assert property (
        @(posedge i_sys_clk) disable iff (i_reset)
        (wr_tx && !clear_cmd)
            |=> (tx_r == ($past(shift_in[7:0]) & RTC_TX_MASK)))
        else $error("transmit control write not stored");

endmodule

// *** test/rtc_host_model.sv ***
// rtc_host_model: host controller on the serial control port.
// assumes the bench calls frame() from one process at a time and that
// the device samples command data on serial clock rises.
`timescale 1ns/1ps

module rtc_host_model (
    input wire logic i_sys_clk,
    input wire logic i_reply_data,
    input wire logic i_reply_data_oe,
    output logic o_select_n,
    output logic o_serial_clk,
    output logic o_command_data
);
    logic last_reply = 1'b0;
    // a released reply line is shown as the inverse of its last bit
    wire logic reply_line = i_reply_data_oe ? i_reply_data : ~last_reply;

    initial begin
        o_select_n = 1'b1;
        o_serial_clk = 1'b0;
        o_command_data = 1'b0;
    end

    always @(posedge i_sys_clk) begin
        if (i_reply_data_oe) begin
            last_reply <= i_reply_data;
        end
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask

    // ------------------------------------------------------------
    // one select-low frame: 8 address bits then ndata bits, msb first
    // ------------------------------------------------------------
    task automatic frame(input logic [7:0] addr, input logic [15:0] wdata,
                         input int ndata, output logic [15:0] rdata,
                         output logic oe_seen);
        logic [23:0] bits;
        bits = {addr, wdata};
        rdata = 16'h0000;
        oe_seen = 1'b0;
        o_select_n = 1'b0;
        wait_clk(3);
        for (int i = 0; i < 8 + ndata; i++) begin
            o_command_data = bits[23 - i];
            wait_clk(5);
            o_serial_clk = 1'b1;
            if (i >= 8) begin
                rdata = {rdata[14:0], reply_line};
            end
            oe_seen = oe_seen | i_reply_data_oe;
            wait_clk(5);
            o_serial_clk = 1'b0;
        end
        // serial clock stays still between frames; data line is driven to the inverse of its last bit
        o_command_data = ~o_command_data;
        wait_clk(8);
        o_select_n = 1'b1;
        wait_clk(6);
    endtask
endmodule

// *** test/rf_transceiver_control_regs_tb_top.sv ***
// rf_transceiver_control_regs_tb_top: self-checking bench for the
// control register bank, driven through the host model's frames.
// assumes the package constants for addresses and writable masks.
`timescale 1ns/1ps

module rf_transceiver_control_regs_tb_top;
    import rtc_pkg::*;

    logic i_sys_clk = 1'b0;
    logic i_reset = 1'b1;
    logic sel_n, sclk, cdata, reply, reply_oe, powersave;
    rtc_ctrl_type ctrl;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] gen_m = RTC_GLOBAL_CLEAR_COMMAND;
    logic [15:0] rx_m = RTC_RX_RST;
    logic [7:0] tx_m = RTC_TX_RST;
    logic [15:0] sy_m = RTC_SYNTH_RST;
    logic [15:0] rd_v;
    logic oe_v;
    logic [1:0] kv;
    logic [2:0] sv;

    always #50 i_sys_clk = ~i_sys_clk;

    rtc_control_regs dut (
        .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_select_n(sel_n),
        .i_serial_clk(sclk), .i_command_data(cdata),
        .o_reply_data(reply), .o_reply_data_oe(reply_oe),
        .o_powersave(powersave), .o_ctrl(ctrl)
    );

    rtc_host_model host (
        .i_sys_clk(i_sys_clk), .i_reply_data(reply),
        .i_reply_data_oe(reply_oe), .o_select_n(sel_n),
        .o_serial_clk(sclk), .o_command_data(cdata)
    );

    // ------------------------------------------------------------
    // expected decode of the model registers, in struct field order
    // ------------------------------------------------------------
    function automatic rtc_ctrl_type exp_ctrl();
        logic [1:0] tg;
        logic [3:0] md;
        tg = (tx_m[7:6] == 2'h3) ? 2'h0 : tx_m[7:6];
        md = sy_m[14:11];
        return {gen_m[7:5], gen_m[3:0], |gen_m, rx_m[15], rx_m[10],
                rx_m[6:5], rx_m[4:3], rx_m[2], rx_m[1:0], &rx_m[1:0],
                tg, tx_m[3], tx_m[2], tx_m[1:0], &tx_m[1:0],
                (md == 4'hc) || (md == 4'hd), md == 4'hd,
                sy_m[10], sy_m[9], sy_m[8]};
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        if (errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // access tasks; only complete frames change the model
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [15:0] d,
                      input int n);
        int full;
        full = (a == RTC_ADDR_CLEAR) ? 0 :
               (a == RTC_ADDR_RX || a == RTC_ADDR_SYNTH) ? 16 : 8;
        host.frame(a, (full == 8) ? {d[7:0], 8'h00} : d, n, rd_v, oe_v);
        if (n == full) begin
            case (a)
                RTC_ADDR_CLEAR: begin
                    gen_m = 8'h00;
                    rx_m = 16'h0000;
                    tx_m = 8'h00;
                    sy_m = 16'h0000;
                end
                RTC_ADDR_GEN: gen_m = d[7:0];
                RTC_ADDR_RX: rx_m = d & RTC_RX_MASK;
                RTC_ADDR_TX: tx_m = d[7:0] & RTC_TX_MASK;
                RTC_ADDR_SYNTH: sy_m = d & RTC_SYNTH_MASK;
                default: ;
            endcase
        end
    endtask

    task automatic check_state();
        cmp({2'h0, ctrl}, {2'h0, exp_ctrl()});
        cmp({31'h0, powersave}, {31'h0, gen_m == 8'h00});
        host.frame(RTC_ADDR_RB_GEN, 16'h0000, 8, rd_v, oe_v);
        cmp({24'h0, rd_v[7:0]}, {24'h0, gen_m});
        host.frame(RTC_ADDR_RB_RX, 16'h0000, 16, rd_v, oe_v);
        cmp({16'h0, rd_v}, {16'h0, rx_m});
        cmp({31'h0, oe_v}, 32'h1);
        host.frame(RTC_ADDR_RB_TX, 16'h0000, 8, rd_v, oe_v);
        cmp({24'h0, rd_v[7:0]}, {24'h0, tx_m});
    endtask

    // a hang counts as a mismatch and ends the run
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge i_sys_clk);
        #1;
        i_reset = 1'b0;
        repeat (3) @(posedge i_sys_clk);
        #1;
        check_state();
        // data 01 written first to an address outside the bank; no register changes
        wr(8'h3f, 16'h0001, 8);
        check_state();
        for (int k = 0; k < 8; k++) begin
            wr(RTC_ADDR_GEN, 16'h0001 << k, 8);
            check_state();
        end
        wr(RTC_ADDR_GEN, 16'h00ff, 8);
        check_state();
        for (int k = 0; k < 4; k++) begin
            kv = k[1:0];
            wr(RTC_ADDR_RX, {kv[0], 4'h0, kv[1], 3'h0, kv, kv, kv[0], kv},
               16);
            check_state();
        end
        // reserved bits written as ones must read back as zero
        wr(RTC_ADDR_RX, 16'hffff, 16);
        check_state();
        for (int k = 0; k < 4; k++) begin
            kv = k[1:0];
            wr(RTC_ADDR_TX, {8'h00, kv, 2'h3, kv[0], kv[1], kv}, 8);
            check_state();
        end
        // mode codes 1110 and 1111 are never sent
        for (int k = 0; k < 8; k++) begin
            sv = k[2:0];
            wr(RTC_ADDR_SYNTH, {1'b1, 2'h3, 1'b0, sv[0], sv[2], sv[0], sv[1],
               8'hff}, 16);
            check_state();
        end
        // a frame cut short by select must not write
        wr(RTC_ADDR_TX, 16'h0000, 4);
        check_state();
        wr(RTC_ADDR_CLEAR, 16'h0000, 0);
        check_state();
        host.frame(8'h40, 16'h0000, 8, rd_v, oe_v);
        cmp({31'h0, oe_v}, 32'h0);
        print_verdict();
    end
endmodule
